// >>> design/tick_defines.svh
`ifndef TICK_DEFINES_SVH
`define TICK_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define PLL_MOD_CTRL_IDX   10'h03a
`define TICK_CTRL_IDX      10'h03b
`define CLK_CTRL_IDX       10'h040
`define TICK_STATUS_IDX    10'h041

// =====================================================================
// Field positions
`define FM_AMP_MSB         5
`define FM_AMP_LSB         4
`define TICK_DEC_BIT       7
`define TICK_PRE_MSB       6
`define TICK_PRE_LSB       4
`define TICK_MOD_MSB       3
`define TICK_MOD_LSB       0
`define CTL_WPROT_BIT      0
`define CTL_PLL_SOURCE_SELECT_BIT     1
`define CTL_PSTOP_BIT      2
`define CTL_TICKSEL_BIT    3
`define CTL_IRQEN_BIT      4
`define STS_FLAG_BIT       0
`define STS_LOCK_BIT       1
`define STS_OSCUP_BIT      2
`define STS_STATE_LSB      3

// =====================================================================
// Reset values
`define PLL_MOD_CTRL_RST   2'h0
`define TICK_CTRL_RST      8'h00
`define PLL_SOURCE_SELECT_RST         1'h1

// =====================================================================
// Prescale divisors and modulation rate
`define BIN_EXP_BASE       5'h09
`define DEC_DIV_0          18'h003e8
`define DEC_DIV_1          18'h007d0
`define DEC_DIV_2          18'h01388
`define DEC_DIV_3          18'h02710
`define DEC_DIV_4          18'h04e20
`define DEC_DIV_5          18'h0c350
`define DEC_DIV_6          18'h186a0
`define DEC_DIV_7          18'h30d40
`define FM_REF_DIV         16

`endif

// >>> design/tick_pkg.sv
`include "tick_defines.svh"

package tick_pkg;

  // Run state of the periodic tick
  typedef enum logic [1:0] {
    st_off,
    st_run,
    st_halt
  } tick_state_t;

  // Prescale divisor; zero means the tick is switched off
  function automatic logic [17:0] prescale_divisor(input logic       dec,
                                                   input logic [2:0] code);
    logic [17:0] div;
    div = 18'h00000;
    if (dec) begin
      case (code)
        3'h0:    div = `DEC_DIV_0;
        3'h1:    div = `DEC_DIV_1;
        3'h2:    div = `DEC_DIV_2;
        3'h3:    div = `DEC_DIV_3;
        3'h4:    div = `DEC_DIV_4;
        3'h5:    div = `DEC_DIV_5;
        3'h6:    div = `DEC_DIV_6;
        default: div = `DEC_DIV_7;
      endcase
    end else if (code != 3'h0) begin
      div = 18'h00001 << (5'(code) + `BIN_EXP_BASE);
    end
    return div;
  endfunction : prescale_divisor

endpackage : tick_pkg

// >>> design/tick_divider.sv
// =====================================================================
// Prescaler followed by modulus counter; one tick per prescale*(modulus+1)
module tick_divider #(
  parameter int DIV_W = 18,
  parameter int MOD_W = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             restart,
  input  wire logic             enable,
  input  wire logic             advance,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic [MOD_W-1:0] modulus,
  output logic                  tick
);

  logic [DIV_W-1:0] pre_count;
  logic [MOD_W-1:0] mod_count;

  // Wrap points of both stages
  wire pre_wrap = (pre_count == (divisor - DIV_W'(1)));
  wire mod_wrap = (mod_count == modulus);

  // Counts only on source pulses; halted counts are kept, not cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count <= '0;
      mod_count <= '0;
      tick      <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (restart || !enable) begin
        pre_count <= '0;
        mod_count <= '0;
      end else if (advance) begin
        if (pre_wrap) begin
          pre_count <= '0;
          if (mod_wrap) begin
            mod_count <= '0;
            tick      <= 1'b1;
          end else begin
            mod_count <= mod_count + MOD_W'(1);
          end
        end else begin
          pre_count <= pre_count + DIV_W'(1);
        end
      end
    end
  end

endmodule : tick_divider

// >>> design/fm_modulator.sv
`include "tick_defines.svh"

// =====================================================================
// Triangle sweep direction for the VCO; one sweep per REF_DIV ref pulses
module fm_modulator #(
  parameter int REF_DIV = `FM_REF_DIV
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic ref_tick,
  output logic      sweep_up
);

  localparam int CW = $clog2(REF_DIV);

  logic [CW-1:0] ref_count;

  // Direction flips at each half of the modulation period
  wire half_done = (ref_count == CW'(REF_DIV / 2 - 1));

  // Held at rest while modulation is off so it starts in a known phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_count <= '0;
      sweep_up  <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        ref_count <= '0;
        sweep_up  <= 1'b0;
      end else if (ref_tick) begin
        if (half_done) begin
          ref_count <= '0;
          sweep_up  <= ~sweep_up;
        end else begin
          ref_count <= ref_count + CW'(1);
        end
      end
    end
  end

endmodule : fm_modulator

// >>> design/tick_fm_ctrl.sv
// What this block and its software do
// RQ1: PLL modulation writes need unprotected, PLL selected
// RQ2: Accepted modulation write clears lock, oscillator-up
// RQ3: Modulation rate is reference over sixteen
// RQ4: Amplitude field: off, 1, 2, 4 percent
// RQ5: Software avoids modulation with adaptive filter
// RQ6: Software keeps bus frequency under maximum
// RQ7: Tick source is RC or crystal
// RQ8: Stop halts tick unless pseudo stop, crystal
// RQ9: Every tick register write restarts period
// RQ10: Tick source change restarts period
// RQ11: Tick register always readable and writable
// RQ12: Bit seven picks binary or decimal prescale
// RQ13: Binary prescale is off or two^10..16
// RQ14: Modulus multiplies divisor by value plus one
// RQ15: Binary prescale zero disables tick; reset default
// RQ16: Decimal prescale one thousand to two hundred thousand
// RQ17: Interrupt when flag set and enabled
// RQ18: Oscillator loss returns tick to RC clock
// RQ19: Period end sets flag, next period starts
// RQ20: Halted tick keeps count, resumes afterwards
`include "tick_defines.svh"

module tick_fm_ctrl #(
  parameter int DIV_W   = 18,
  parameter int MOD_W   = 4,
  parameter int REF_DIV = `FM_REF_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irc_tick,
  input  wire logic        osc_tick,
  input  wire logic        ref_tick,
  input  wire logic        stop_mode,
  input  wire logic        pll_lock_in,
  input  wire logic        osc_ok_in,
  output logic             tick_irq,
  output logic             tick_pulse,
  output logic      [1:0]  fm_amplitude,
  output logic             fm_sweep_up
);

  // ===================================================================
  // State
  logic [7:0]               tick_ctrl;
  logic                     write_protect_flag;
  logic                     pll_source_select;
  logic                     pseudo_stop_select;
  logic                     tick_clock_select;
  logic                     tick_irq_enable;
  logic                     tick_flag;
  logic                     pll_locked;
  logic                     osc_up_status;
  logic                     osc_ok_prev;
  logic                     lock_prev;
  tick_pkg::tick_state_t    tick_state;
  tick_pkg::tick_state_t    next_tick_state;

  // ===================================================================
  // APB decode
  wire [9:0] reg_idx     = paddr[11:2];
  wire       aligned     = (paddr[1:0] == 2'h0);
  wire       hit_pll     = aligned && (reg_idx == `PLL_MOD_CTRL_IDX);
  wire       hit_tick    = aligned && (reg_idx == `TICK_CTRL_IDX);
  wire       hit_ctl     = aligned && (reg_idx == `CLK_CTRL_IDX);
  wire       hit_sts     = aligned && (reg_idx == `TICK_STATUS_IDX);
  wire       mapped      = hit_pll | hit_tick | hit_ctl | hit_sts;
  wire       setup_phase = psel & ~penable;
  // Writes land only at the edge that completes the access phase
  wire       access_done = psel & penable & pready;
  wire       wr_done     = access_done & pwrite & pstrb[0];

  // Per-register write strobes
  wire pll_wr_ok = wr_done & hit_pll & ~write_protect_flag
                 & pll_source_select;                          // RQ1
  wire tick_wr   = wr_done & hit_tick;                          // RQ11
  wire ctl_wr    = wr_done & hit_ctl;
  wire sts_wr    = wr_done & hit_sts;

  // ===================================================================
  // Oscillator and lock status
  wire osc_rise  = osc_ok_in & ~osc_ok_prev;
  wire osc_fall  = ~osc_ok_in & osc_ok_prev;
  wire lock_rise = pll_lock_in & ~lock_prev;

  // A fresh rising edge wins over a clearing write in the same cycle
  wire next_osc_up = osc_rise
                   | (osc_up_status & ~osc_fall & ~pll_wr_ok);   // RQ2
  wire next_locked = lock_rise
                   | (pll_locked & pll_lock_in & ~pll_wr_ok);    // RQ2
  wire osc_lost    = osc_up_status & ~next_osc_up;

  // ===================================================================
  // Tick source select
  // The crystal can only be chosen while it is reported up
  wire sel_written = pwdata[`CTL_TICKSEL_BIT] & osc_up_status;
  wire next_tick_clock_select = osc_lost ? 1'b0 :                 // RQ18
                                ctl_wr   ? sel_written :
                                           tick_clock_select;
  wire sel_changed = (next_tick_clock_select != tick_clock_select);
  wire tick_restart = tick_wr | sel_changed;                     // RQ9 RQ10

  // ===================================================================
  // Tick rate decode
  wire             tick_dec   = tick_ctrl[`TICK_DEC_BIT];        // RQ12
  wire [2:0]       tick_pre   = tick_ctrl[`TICK_PRE_MSB:`TICK_PRE_LSB];
  wire [MOD_W-1:0] tick_mod   = tick_ctrl[`TICK_MOD_MSB:`TICK_MOD_LSB]; // RQ14
  wire [17:0]      pre_div    = tick_pkg::prescale_divisor(tick_dec,
                                                           tick_pre); // RQ13 RQ16
  wire             tick_off   = (pre_div == 18'h00000);          // RQ15
  // Only pseudo stop with the crystal keeps the source alive in stop
  wire             tick_run   = ~stop_mode
                              | (pseudo_stop_select & tick_clock_select); // RQ8
  wire             tick_src   = tick_clock_select ? osc_tick : irc_tick;  // RQ7
  wire             tick_adv   = tick_src & tick_run;             // RQ20

  // ===================================================================
  // Tick flag, cleared by writing one; a tick in that cycle wins
  wire flag_clear     = sts_wr & pwdata[`STS_FLAG_BIT];
  wire next_tick_flag = tick_pulse | (tick_flag & ~flag_clear);  // RQ19
  wire next_irq_en    = ctl_wr ? pwdata[`CTL_IRQEN_BIT] : tick_irq_enable;

  // Run state for software visibility
  always_comb begin
    if (tick_off) begin
      next_tick_state = tick_pkg::st_off;
    end else if (!tick_run) begin
      next_tick_state = tick_pkg::st_halt;
    end else begin
      next_tick_state = tick_pkg::st_run;
    end
  end

  // Encoding of the run state in the status word
  logic [1:0] state_code;
  always_comb begin
    case (tick_state)
      tick_pkg::st_off:  state_code = 2'h0;
      tick_pkg::st_run:  state_code = 2'h1;
      tick_pkg::st_halt: state_code = 2'h2;
      default:           state_code = 2'h3;
    endcase
  end

  // ===================================================================
  // Read words
  wire [31:0] pll_word  = {26'h0, fm_amplitude, 4'h0};
  wire [31:0] tick_word = {24'h0, tick_ctrl};
  logic [31:0] ctl_word;
  logic [31:0] sts_word;
  always_comb begin
    ctl_word                   = 32'h0;
    ctl_word[`CTL_WPROT_BIT]   = write_protect_flag;
    ctl_word[`CTL_PLL_SOURCE_SELECT_BIT]  = pll_source_select;
    ctl_word[`CTL_PSTOP_BIT]   = pseudo_stop_select;
    ctl_word[`CTL_TICKSEL_BIT] = tick_clock_select;
    ctl_word[`CTL_IRQEN_BIT]   = tick_irq_enable;
  end

  // Status word: flag, lock, oscillator, run state
  always_comb begin
    sts_word                                      = 32'h0;
    sts_word[`STS_FLAG_BIT]                       = tick_flag;
    sts_word[`STS_LOCK_BIT]                       = pll_locked;
    sts_word[`STS_OSCUP_BIT]                      = osc_up_status;
    sts_word[`STS_STATE_LSB+1:`STS_STATE_LSB]     = state_code;
  end

  // Reads are never gated; unmapped addresses read zero
  wire [31:0] read_word = hit_pll  ? pll_word  :
                          hit_tick ? tick_word :
                          hit_ctl  ? ctl_word  :
                          hit_sts  ? sts_word  : 32'h0;

  // ===================================================================
  // APB answer: one wait-free access phase, data from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (ce) begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0 : read_word;
      end
    end
  end

  // ===================================================================
  // PLL modulation amplitude
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fm_amplitude <= `PLL_MOD_CTRL_RST;
    end else if (ce && pll_wr_ok) begin
      fm_amplitude <= pwdata[`FM_AMP_MSB:`FM_AMP_LSB];            // RQ4
    end
  end

  // ===================================================================
  // Tick control register, open to every write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ctrl <= `TICK_CTRL_RST;
    end else if (ce && tick_wr) begin
      tick_ctrl <= pwdata[7:0];                                  // RQ11
    end
  end

  // ===================================================================
  // Clock control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_protect_flag <= 1'b0;
      pll_source_select  <= `PLL_SOURCE_SELECT_RST;
      pseudo_stop_select <= 1'b0;
      tick_irq_enable    <= 1'b0;
    end else if (ce && ctl_wr) begin
      write_protect_flag <= pwdata[`CTL_WPROT_BIT];
      pll_source_select  <= pwdata[`CTL_PLL_SOURCE_SELECT_BIT];
      pseudo_stop_select <= pwdata[`CTL_PSTOP_BIT];
      tick_irq_enable    <= pwdata[`CTL_IRQEN_BIT];
    end
  end

  // Source select is also cleared by hardware on oscillator loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_clock_select <= 1'b0;
    end else if (ce) begin
      tick_clock_select <= next_tick_clock_select;               // RQ18
    end
  end

  // ===================================================================
  // Status, edge history and run state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ok_prev   <= 1'b0;
      lock_prev     <= 1'b0;
      osc_up_status <= 1'b0;
      pll_locked    <= 1'b0;
      tick_flag     <= 1'b0;
      tick_state    <= tick_pkg::st_off;
    end else if (ce) begin
      osc_ok_prev   <= osc_ok_in;
      lock_prev     <= pll_lock_in;
      osc_up_status <= next_osc_up;
      pll_locked    <= next_locked;
      tick_flag     <= next_tick_flag;                           // RQ19
      tick_state    <= next_tick_state;
    end
  end

  // Interrupt rises in the same cycle as the flag, from the next flag and enable values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_irq <= 1'b0;
    end else if (ce) begin
      tick_irq <= next_tick_flag & next_irq_en;                   // RQ17
    end
  end

  // ===================================================================
  // Tick divider; restart clears both stages, a halt only freezes them
  tick_divider #(
    .DIV_W (DIV_W),
    .MOD_W (MOD_W)
  ) u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (tick_restart),                                     // RQ9 RQ10
    .enable  (~tick_off),                                        // RQ15
    .advance (tick_adv),                                         // RQ8 RQ20
    .divisor (DIV_W'(pre_div)),
    .modulus (tick_mod),                                         // RQ14
    .tick    (tick_pulse)                                        // RQ19
  );

  // ===================================================================
  // VCO frequency modulation sweep, active for any nonzero amplitude
  fm_modulator #(
    .REF_DIV (REF_DIV)
  ) u_fm (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .enable   (fm_amplitude != 2'h0),                            // RQ4
    .ref_tick (ref_tick),                                        // RQ3
    .sweep_up (fm_sweep_up)
  );

endmodule : tick_fm_ctrl

// >>> dv/tick_fm_ctrl_checker.sv
`include "tick_defines.svh"

// =====================================================================
// Pin-level checks for the tick and modulation control block
module tick_fm_ctrl_checker #(
  parameter int REF_DIV = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        irc_tick,
  input wire logic        osc_tick,
  input wire logic        ref_tick,
  input wire logic        stop_mode,
  input wire logic        tick_irq,
  input wire logic        tick_pulse,
  input wire logic [1:0]  fm_amplitude,
  input wire logic        fm_sweep_up
);
  timeunit 1ns;
  timeprecision 1ps;

  logic wr_done, mod_wr, tick_wr, ctl_wr;
  int   rc;
  logic wp_m, ps_m, pstop_m, ie_m, off_m;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // =====================================================================
  // Completed writes; only byte 0 carries register bits
  assign wr_done = psel & penable & pready & pwrite & pstrb[0];
  assign mod_wr  = wr_done & (paddr == {`PLL_MOD_CTRL_IDX, 2'b00});
  assign tick_wr = wr_done & (paddr == {`TICK_CTRL_IDX, 2'b00});
  assign ctl_wr  = wr_done & (paddr == {`CLK_CTRL_IDX, 2'b00});

  // Shadow of control bits, so gating can be judged from the pins alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_m    <= 1'b0;
      ps_m    <= 1'b1;
      pstop_m <= 1'b0;
      ie_m    <= 1'b0;
      off_m   <= 1'b1;
      rc      <= 0;
    end else begin
      // Reference pulses into the current half sweep; parked while modulation is off
      if (fm_amplitude == 2'h0 || (ref_tick && rc == REF_DIV / 2 - 1)) rc <= 0;
      else if (ref_tick) rc <= rc + 1;
      if (ctl_wr) begin
        wp_m    <= pwdata[0];
        ps_m    <= pwdata[1];
        pstop_m <= pwdata[2];
        ie_m    <= pwdata[4];
      end
      if (tick_wr) begin
        off_m <= (pwdata[7:4] == 4'h0);
      end
    end
  end

  // =====================================================================
  // Assertions
  ready_setup_a: assert property (psel && !penable && ce |=> pready)
    else $error("no answer after setup");
  fm_write_a: assert property (mod_wr && !wp_m && ps_m |=>
    fm_amplitude == $past(pwdata[5:4]))
    else $error("accepted amplitude write lost");
  fm_refuse_a: assert property (mod_wr && (wp_m || !ps_m) |=> $stable(fm_amplitude))
    else $error("gated amplitude write took effect");
  fm_off_a: assert property (fm_amplitude == 2'h0 && $past(fm_amplitude) == 2'h0
    |-> !fm_sweep_up)
    else $error("sweep active with modulation off");
  fm_step_a: assert property (fm_amplitude != 2'h0 |=>
    $changed(fm_sweep_up) == $past(ref_tick && rc == REF_DIV / 2 - 1))
    else $error("sweep step off the reference rate");
  tick_source_a: assert property (tick_pulse |-> $past(irc_tick || osc_tick))
    else $error("tick without a source pulse");
  tick_off_a: assert property (off_m && $past(off_m) |-> !tick_pulse)
    else $error("tick while prescaler off");
  tick_halt_a: assert property ($past(stop_mode) && !$past(pstop_m) |-> !tick_pulse)
    else $error("tick during full stop");
  tick_restart_a: assert property (tick_wr |=> !tick_pulse [*8])
    else $error("tick right after control write");
  tick_irq_a: assert property (tick_pulse && ie_m |=> tick_irq)
    else $error("enabled tick raised no request");
  tick_once_a: assert property (tick_pulse |=> !tick_pulse)
    else $error("tick pulse longer than one cycle");

  cover property (tick_pulse && ie_m);
  cover property (mod_wr && wp_m);
  cover property (stop_mode && tick_pulse);
endmodule : tick_fm_ctrl_checker

bind tick_fm_ctrl tick_fm_ctrl_checker #(.REF_DIV(REF_DIV)) u_chk (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
  .irc_tick, .osc_tick, .ref_tick, .stop_mode, .tick_irq, .tick_pulse, .fm_amplitude,
  .fm_sweep_up
);

// >>> dv/test_periodic_tick_and_pll_fm_control.sv
`include "tick_defines.svh"

// =====================================================================
// Self-checking bench for the tick and modulation control block
module test_periodic_tick_and_pll_fm_control;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] A_MOD  = {`PLL_MOD_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_TICK = {`TICK_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_CTL  = {`CLK_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STS  = {`TICK_STATUS_IDX, 2'b00};
  localparam logic [32:0] ERR_M  = 33'h1_0000_0000;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, irc_tick, osc_tick, ref_tick;
  logic        stop_mode, pll_lock_in, osc_ok_in, pslverr, pready;
  logic        tick_irq, tick_pulse, fm_sweep_up;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pstrb;
  logic [1:0]  fm_amplitude;
  logic [32:0] exp_q[$], msk_q[$], e, mk;
  int unsigned tk_q[$], pcnt, seed;
  int          failures, checks, i, m;
  bit          irc_en, osc_en, clr, cnt_en = 1'b1;

  always #10 pclk = ~pclk;

  tick_fm_ctrl u_tick_fm_ctrl (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .irc_tick, .osc_tick, .ref_tick, .stop_mode, .pll_lock_in,
    .osc_ok_in, .tick_irq, .tick_pulse, .fm_amplitude, .fm_sweep_up
  );

  // =====================================================================
  // Sources pulse every other cycle, so no pulse lands on the edge showing a tick
  always @(posedge pclk) begin
    irc_tick <= irc_en & ~irc_tick;
    osc_tick <= osc_en & ~osc_tick;
    ref_tick <= ~ref_tick;
    if (clr || tick_pulse === 1'b1) pcnt <= 0;
    else if (cnt_en && (irc_tick || osc_tick)) pcnt <= pcnt + 1;
  end

  task automatic fail(input string s);
    failures++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask : fail

  task automatic chk(input bit ok, input string s);
    checks++;
    if (!ok) fail(s);
  endtask : chk

  task automatic end_sim;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // =====================================================================
  // Answers and ticks are matched against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected bus answer");
      else begin
        e = exp_q.pop_front();
        mk = msk_q.pop_front();
        chk(({pslverr, prdata} & mk) === (e & mk), "bus answer");
      end
    end
    if (tick_pulse === 1'b1) begin
      if (tk_q.size() == 0) fail("unexpected tick");
      else chk(pcnt == tk_q.pop_front(), "tick period");
    end
  end

  // Holds the request until pready is sampled high; no cycle count assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex, input logic [32:0] msk);
    int n;
    exp_q.push_back(ex);
    msk_q.push_back(msk);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail("bus timeout");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, ERR_M);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [32:0] ex, input logic [32:0] msk);
    apb(1'b0, a, 32'h0, ex, msk);
  endtask : rd

  // Run a source until the noted ticks arrive; optional halt in full stop
  task automatic go(input bit osc, input int unsigned n, input int reps, input int halt_at);
    int k;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (reps) tk_q.push_back(n);
    if (osc) osc_en <= 1'b1;
    else irc_en <= 1'b1;
    k = 0;
    while (tk_q.size() != 0 && k < 6 * n * reps) begin
      @(posedge pclk);
      k++;
      if (k == halt_at) begin
        stop_mode <= 1'b1;
        cnt_en <= 1'b0;
        repeat (400) @(posedge pclk);
        stop_mode <= 1'b0;
        cnt_en <= 1'b1;
      end
    end
    if (tk_q.size() != 0) fail("tick missing");
    tk_q.delete();
    irc_en <= 1'b0;
    osc_en <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : go

  // Crystal or RC pulses for a part period, then sources idle
  task automatic part(input bit osc);
    if (osc) osc_en <= 1'b1;
    else irc_en <= 1'b1;
    repeat (600) @(posedge pclk);
    irc_en <= 1'b0;
    osc_en <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : part

  // =====================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, irc_tick, osc_tick, ref_tick} = 6'h00;
    {stop_mode, pll_lock_in, osc_ok_in} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    seed = $urandom(4726);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_TICK, 33'h0, 33'hff);
    rd(A_CTL, 33'h2, 33'h1f);
    apb(1'b0, 12'h200, 32'h0, ERR_M, ERR_M | 33'hffff_ffff);
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      wr(A_MOD, {v[31:6], i[1:0], v[3:0]});
      rd(A_MOD, {27'h0, i[1:0], 4'h0}, 33'hff);
      chk(fm_amplitude === i[1:0], "amplitude output");
    end
    wr(A_CTL, 32'h3);
    wr(A_MOD, 32'h10);
    wr(A_CTL, 32'h0);
    wr(A_MOD, 32'h20);
    rd(A_MOD, 33'h30, 33'hff);
    wr(A_CTL, 32'h2);
    pll_lock_in <= 1'b1;
    osc_ok_in <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(A_STS, 33'h6, 33'h6);
    wr(A_MOD, 32'h10);
    rd(A_STS, 33'h0, 33'h6);
    wr(A_CTL, 32'h12);
    wr(A_TICK, 32'h10);
    go(1'b0, 1024, 2, 0);
    chk(tick_irq === 1'b1, "request not raised");
    wr(A_STS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(tick_irq === 1'b0, "request not cleared");
    wr(A_TICK, 32'h11);
    go(1'b0, 2048, 2, 0);
    m = $urandom_range(3, 0);
    wr(A_TICK, 32'h80 | m);
    go(1'b0, 1000 * (m + 1), 1, 0);
    wr(A_TICK, 32'h91);
    go(1'b0, 4000, 1, 0);
    wr(A_TICK, 32'h10);
    go(1'b0, 1024, 1, 600);
    part(1'b0);
    wr(A_TICK, 32'h10);
    go(1'b0, 1024, 1, 0);
    wr(A_TICK, 32'h00);
    irc_en <= 1'b1;
    repeat (2200) @(posedge pclk);
    irc_en <= 1'b0;
    osc_ok_in <= 1'b0;
    repeat (4) @(posedge pclk);
    osc_ok_in <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(A_CTL, 32'h0e);
    rd(A_CTL, 33'he, 33'h1f);
    stop_mode <= 1'b1;
    wr(A_TICK, 32'h10);
    go(1'b1, 1024, 1, 0);
    stop_mode <= 1'b0;
    part(1'b1);
    osc_ok_in <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(A_CTL, 33'h6, 33'h1f);
    go(1'b0, 1024, 1, 0);
    end_sim();
  end

  // Cuts a hang short; the whole sequence needs well under 60k cycles
  initial begin
    #2000000;
    fail("run timeout");
    end_sim();
  end
endmodule : test_periodic_tick_and_pll_fm_control
